// ==== rtl/prb_pkg.sv ====
// Constants for the protection region base register block
package prb_pkg;
    // --------------------------------------------------------------
    // Register byte offsets
    // --------------------------------------------------------------
    localparam logic [11:0] OFS_ACTIVE_SLOT_INDEX   = 12'h000;
    localparam logic [11:0] OFS_SLOT_BASE_REGISTER  = 12'h004;
    localparam logic [11:0] OFS_SLOT_ATTRIBUTE_SIZE = 12'h008;
    localparam int          ADDR_W                  = 12;

    // --------------------------------------------------------------
    // Field layout
    // --------------------------------------------------------------
    localparam int          SLOT_LSB     = 0;
    localparam int          SLOT_W       = 4;
    localparam int          UPDATE_BIT   = 4;
    localparam int          SIZE_LSB     = 1;
    localparam int          SIZE_W       = 5;
    localparam int          MAX_SLOTS    = 16;
    localparam logic [4:0]  SIZE_MIN     = 5'h04;
    localparam logic [4:0]  SIZE_FULL    = 5'h1f;
    localparam logic [31:0] BASE_FULL    = 32'h00000000;

    // --------------------------------------------------------------
    // Bus answers and reset values
    // --------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    localparam logic [31:0] RESET_BASE   = 32'h00000000;
    localparam logic [4:0]  RESET_SIZE   = 5'h04;
    localparam logic [3:0]  RESET_SLOT   = 4'h0;
endpackage

// ==== rtl/prb_region_base.sv ====
// Region base register block with AXI4-Lite register access
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module prb_region_base
    import prb_pkg::*;
#(
    parameter int NUM_SLOTS = 8
) (
    // Clock and reset
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0]         s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    // Region view for the protection checker
    output logic [SLOT_W-1:0]              active_slot,
    output logic [NUM_SLOTS*32-1:0]        region_base,
    output logic [NUM_SLOTS*SIZE_W-1:0]    region_size
);

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    if (NUM_SLOTS < 1 || NUM_SLOTS > MAX_SLOTS) begin : g_chk
        $error("NUM_SLOTS must lie between 1 and 16");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                               aw_got;
        logic [ADDR_W-1:0]                  awaddr;
        logic                               w_got;
        logic [31:0]                        wdata;
        logic [3:0]                         wstrb;
        logic                               bvalid;
        logic [1:0]                         bresp;
        logic                               rvalid;
        logic [1:0]                         rresp;
        logic [31:0]                        rdata;
        logic [SLOT_W-1:0]                  slot;
        logic [NUM_SLOTS-1:0][31:0]         base;
        logic [NUM_SLOTS-1:0][SIZE_W-1:0]   size;
    } prb_state_t;

    prb_state_t state_reg;
    prb_state_t state_next;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Keeps bits 31..N with N = size + 1; a full-map size keeps nothing
    function automatic logic [31:0] base_mask(input logic [SIZE_W-1:0] sz);
        logic [32:0] m;
        m = 33'h1ffffffff << (6'(sz) + 6'h01);
        return m[31:0];
    endfunction

    function automatic logic slot_ok(input logic [SLOT_W-1:0] s);
        return 32'(s) < NUM_SLOTS;
    endfunction

    function automatic logic [33:0] reg_read(input logic [ADDR_W-1:0] a, input prb_state_t st);
        logic [31:0] d;
        logic [1:0]  rsp;
        d   = 32'h00000000;
        rsp = RESP_OKAY;
        case ({a[ADDR_W-1:2], 2'h0})
            OFS_ACTIVE_SLOT_INDEX:   d[SLOT_LSB +: SLOT_W] = st.slot;
            OFS_SLOT_BASE_REGISTER: begin
                // Update flag stays zero in d
                d = st.base[st.slot];
                d[SLOT_LSB +: SLOT_W] = st.slot;
            end
            OFS_SLOT_ATTRIBUTE_SIZE: d[SIZE_LSB +: SIZE_W] = st.size[st.slot];
            default:                 rsp = RESP_SLVERR;
        endcase
        return {rsp, d};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] v;
        v = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                v[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return v;
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [33:0]       rd;
        logic [31:0]       wd;
        logic [SLOT_W-1:0] tgt;
        logic [SIZE_W-1:0] nsz;
        rd  = 34'h000000000;
        wd  = 32'h00000000;
        tgt = RESET_SLOT;
        nsz = RESET_SIZE;
        state_next = state_reg;

        if (s_axi_awvalid && s_axi_awready) begin
            state_next.aw_got = 1'b1;
            state_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            state_next.w_got = 1'b1;
            state_next.wdata = s_axi_wdata;
            state_next.wstrb = s_axi_wstrb;
        end
        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end

        // Both halves held: perform the write, then answer
        if (state_reg.aw_got && state_reg.w_got && !state_reg.bvalid) begin
            rd = reg_read(state_reg.awaddr, state_reg);
            wd = merge(rd[31:0], state_reg.wdata, state_reg.wstrb);
            state_next.aw_got = 1'b0;
            state_next.w_got  = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp  = rd[33:32];
            case ({state_reg.awaddr[ADDR_W-1:2], 2'h0})
                OFS_ACTIVE_SLOT_INDEX: begin
                    if (slot_ok(wd[SLOT_LSB +: SLOT_W])) begin
                        state_next.slot = wd[SLOT_LSB +: SLOT_W];
                    end
                end
                OFS_SLOT_BASE_REGISTER: begin
                    // Out-of-range region numbers drop the whole write
                    tgt = wd[UPDATE_BIT] ? wd[SLOT_LSB +: SLOT_W] : state_reg.slot;
                    if (slot_ok(tgt)) begin
                        state_next.slot      = tgt;
                        state_next.base[tgt] = wd & base_mask(state_reg.size[tgt]);
                    end
                end
                OFS_SLOT_ATTRIBUTE_SIZE: begin
                    // Sizes below 32 bytes are not supported; clamp keeps the mask sane
                    nsz = wd[SIZE_LSB +: SIZE_W];
                    if (nsz < SIZE_MIN) begin
                        nsz = SIZE_MIN;
                    end
                    state_next.size[state_reg.slot] = nsz;
                    // Growing the size drops low base bits; full map forces zero
                    state_next.base[state_reg.slot] = state_reg.base[state_reg.slot] & base_mask(nsz);
                end
                default: begin
                end
            endcase
        end

        if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            {state_next.rresp, state_next.rdata} = reg_read(s_axi_araddr, state_reg);
            state_next.rvalid = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= '0;
            for (int i = 0; i < NUM_SLOTS; i++) begin
                state_reg.base[i] <= RESET_BASE;
                state_reg.size[i] <= RESET_SIZE;
            end
            state_reg.slot <= RESET_SLOT;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign s_axi_awready = !state_reg.aw_got && !state_reg.bvalid;
    assign s_axi_wready  = !state_reg.w_got && !state_reg.bvalid;
    assign s_axi_bvalid  = state_reg.bvalid;
    assign s_axi_bresp   = state_reg.bresp;
    assign s_axi_arready = !state_reg.rvalid;
    assign s_axi_rvalid  = state_reg.rvalid;
    assign s_axi_rdata   = state_reg.rdata;
    assign s_axi_rresp   = state_reg.rresp;
    assign active_slot   = state_reg.slot;
    assign region_base   = state_reg.base;
    assign region_size   = state_reg.size;

endmodule

// ==== testbench/prb_region_base_sva.sv ====
// Checker for the region base register block ports
`timescale 1ns/1ps
module prb_region_base_sva
    import prb_pkg::*;
#(
    parameter int NUM_SLOTS = 8
) (
    // Clock, reset and bus
    input wire logic                   aclk,
    input wire logic                   aresetn,
    input wire logic [ADDR_W-1:0]      s_axi_awaddr,
    input wire logic                   s_axi_awvalid,
    input wire logic                   s_axi_awready,
    input wire logic [31:0]            s_axi_wdata,
    input wire logic                   s_axi_wvalid,
    input wire logic                   s_axi_wready,
    input wire logic [1:0]             s_axi_bresp,
    input wire logic                   s_axi_bvalid,
    input wire logic                   s_axi_bready,
    input wire logic                   s_axi_arvalid,
    input wire logic                   s_axi_arready,
    input wire logic [31:0]            s_axi_rdata,
    input wire logic                   s_axi_rvalid,
    input wire logic                   s_axi_rready,
    // Region view
    input wire logic [SLOT_W-1:0]      active_slot,
    input wire logic [NUM_SLOTS*32-1:0] region_base,
    input wire logic [NUM_SLOTS*SIZE_W-1:0] region_size
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [32:0] low_mask;
    // Low bits of the selected base that must read zero; 4 GB clears all
    always_comb begin
        low_mask = (33'h1 << (6'(region_size[active_slot*SIZE_W +: SIZE_W]) + 6'h1)) - 33'h1;
    end
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_base_wr;
        s_wr_take ##0 (s_axi_awaddr[11:2] == OFS_SLOT_BASE_REGISTER[11:2]);
    endsequence
    AST_BVALID_LAT: assert property (s_wr_take |-> !s_axi_bvalid ##2 s_axi_bvalid) else $error("bvalid late");
    AST_RVALID_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("rvalid late");
    AST_BSTAND: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    AST_RSTAND: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    AST_SLOT_HOLD: assert property (s_base_wr ##0 !s_axi_wdata[UPDATE_BIT] |=> $stable(active_slot)[*2])
        else $error("slot moved on plain base write");
    AST_SLOT_LOAD: assert property (s_base_wr ##0 s_axi_wdata[UPDATE_BIT] && s_axi_wdata[3:0] < NUM_SLOTS
        |-> ##2 active_slot == $past(s_axi_wdata[3:0], 2)) else $error("slot not loaded");
    AST_ALIGN: assert property ((region_base[active_slot*32 +: 32] & low_mask[31:0]) == 32'h0)
        else $error("base bits below size");
endmodule
bind prb_region_base prb_region_base_sva #(.NUM_SLOTS(NUM_SLOTS)) u_sva (.*);

// ==== testbench/prb_region_base_tb.sv ====
// Self-checking bench for the region base register block
`timescale 1ns/1ps
module prb_region_base_tb;
    import prb_pkg::*;
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] awa = '0, ara = '0;
    logic [31:0] wd = '0, rdat, rd;
    logic awv = 0, wv = 0, bv, brd = 0, arv = 0, rv, rrd = 0, awr, wr, arr;
    logic [1:0] br, rr, rsp;
    logic [3:0] slot;
    logic [63:0] ex;
    logic [8*32-1:0] bases;
    logic [8*SIZE_W-1:0] sizes;
    int failures = 0, comparisons = 0, cycles = 0;
    int codes[5] = '{4, 9, 15, 30, 31};
    always #50 aclk = ~aclk;
    prb_region_base #(.NUM_SLOTS(8)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(ara),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rrd), .active_slot(slot), .region_base(bases), .region_size(sizes));
    task automatic finish_test();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, done;
        done = 0;
        // One idle edge keeps bready from being lowered and raised in one step
        @(posedge aclk);
        awa <= a; wd <= d; awv <= 1; wv <= 1; brd <= 1;
        while (!done) begin
            @(negedge aclk); ta = awr; tw = wr; done = bv; r = br;
            @(posedge aclk); if (ta) awv <= 0; if (tw) wv <= 0;
        end
        brd <= 0;
    endtask
    task automatic rd_reg(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, done;
        done = 0;
        @(posedge aclk);
        ara <= a; arv <= 1; rrd <= 1;
        while (!done) begin
            @(negedge aclk); ta = arr; done = rv; d = rdat; r = rr;
            @(posedge aclk); if (ta) arv <= 0;
        end
        rrd <= 0;
    endtask
    // Hang guard: the whole sequence needs about 125 cycles
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 3000) begin failures++; finish_test(); end
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_reg(OFS_SLOT_BASE_REGISTER, rd, rsp); `CHK(rd, 32'h0)
        rd_reg(OFS_ACTIVE_SLOT_INDEX, rd, rsp); `CHK(rd[3:0], 4'h0)
        $display("test reset done");
        wr_reg(OFS_SLOT_BASE_REGISTER, 32'h12345673, rsp); `CHK(slot, 4'h3)
        rd_reg(OFS_SLOT_BASE_REGISTER, rd, rsp); `CHK(rd, 32'h12345663)
        wr_reg(OFS_SLOT_BASE_REGISTER, 32'habcd0005, rsp); `CHK(slot, 4'h3)
        rd_reg(OFS_SLOT_BASE_REGISTER, rd, rsp); `CHK(rd, 32'habcd0003)
        `CHK(bases[3*32 +: 32], 32'habcd0000)
        `CHK(bases[5*32 +: 32], 32'h0)
        $display("test update flag done");
        foreach (codes[i]) begin
            ex = 64'hffffffff << (codes[i] + 1);
            wr_reg(OFS_SLOT_ATTRIBUTE_SIZE, 32'(codes[i]) << 1, rsp);
            wr_reg(OFS_SLOT_BASE_REGISTER, (codes[i] == 31) ? 32'hffffffe0 : ex[31:0], rsp);
            rd_reg(OFS_SLOT_BASE_REGISTER, rd, rsp); `CHK(rd, ex[31:0] | 32'h3)
        end
        `CHK(sizes[3*SIZE_W +: SIZE_W], SIZE_FULL)
        $display("test size sweep done");
        wr_reg(12'h00c, 32'h1, rsp); `CHK(rsp, RESP_SLVERR)
        rd_reg(12'h00c, rd, rsp); `CHK(rsp, RESP_SLVERR)
        wr_reg(OFS_ACTIVE_SLOT_INDEX, 32'h00000005, rsp); `CHK(slot, 4'h5)
        wr_reg(OFS_ACTIVE_SLOT_INDEX, 32'h0000000c, rsp); `CHK(slot, 4'h5)
        rd_reg(OFS_SLOT_BASE_REGISTER, rd, rsp); `CHK(rd, 32'h00000005)
        wr_reg(OFS_SLOT_BASE_REGISTER, 32'h00000f89, rsp); `CHK(bases[5*32 +: 32], 32'h00000f80)
        `CHK(slot, 4'h5)
        rd_reg(OFS_SLOT_ATTRIBUTE_SIZE, rd, rsp); `CHK(rd, 32'h00000008)
        $display("test index register done");
        wr_reg(OFS_SLOT_BASE_REGISTER, 32'h00000010, rsp); `CHK(slot, 4'h0)
        rd_reg(OFS_SLOT_BASE_REGISTER, rd, rsp); `CHK(rd, 32'h0)
        $display("test reselect done");
        finish_test();
    end
endmodule
